// [pkg/twmt_defs.svh]
`ifndef TWMT_DEFS_SVH
`define TWMT_DEFS_SVH
// Parameter memory: 128 words addressable, 100 built
`define TWMT_PMEM_IMPL 7'h64
`define TWMT_PMEM_TOP 12'h200
// Register byte offsets
`define TWMT_TOOTH_CTRL 12'h200
`define TWMT_TOOTH_STAT 12'h204
`define TWMT_ANGLE 12'h208
`define TWMT_TBASE 12'h20C
`define TWMT_STEP_CTRL 12'h210
`define TWMT_STEP_K 12'h214
`define TWMT_STEP_TGT 12'h218
`define TWMT_STEP_SLEW 12'h21C
`define TWMT_STEP_PAT_HI 7'h11
`define TWMT_ACC_CTRL 12'h240
`define TWMT_ACC_RES 12'h244
`define TWMT_QPOS 12'h248
`define TWMT_QSTAMP 12'h24C
`define TWMT_STATUS 12'h250
`define TWMT_PROJ_HI 5'h05
// Field positions
`define TWMT_TOOTH_EN 0
`define TWMT_TOOTH_MISS 1
`define TWMT_TOOTH_FLAG 2
`define TWMT_STEP_TABLE 0
`define TWMT_STEP_REQ 7
`define TWMT_ACC_EN 0
`define TWMT_ACC_HIGH 1
`define TWMT_ACC_WIDE 2
`define TWMT_ACC_LINK 24
`define TWMT_PROJ_EN 30
`define TWMT_PROJ_TIME 31
// Values
`define TWMT_CTRL_RST 32'h0000_0000
`define TWMT_ANGLE_RESET 16'hFFFF
`define TWMT_RATIO_SHIFT 6
`define TWMT_FRAC_SHIFT 8
`define TWMT_SM_MAX_RATE 6'h0E
`define TWMT_TSM_MAX_RATE 6'h3A
`define TWMT_TABLE_BASE 7'h20
`define TWMT_LINK_MAX 4'h8
`endif

// [pkg/twmt_pkg.sv]
package twmt_pkg;
   typedef enum logic [1:0] {
      pj_idle = 2'h0,
      pj_delay = 2'h1,
      pj_pulse = 2'h3
   } twmt_proj_e;
   typedef enum logic {
      st_idle = 1'h0,
      st_run = 1'h1
   } twmt_step_e;
endpackage : twmt_pkg

// [verilog/twmt_top.sv]
// The AHB-Lite slave port and the register offsets were decided locally.
`timescale 1ns/10ps
`include "twmt_defs.svh"
module twmt_top #(
   parameter int PROJ_CH = 15,
   parameter int STEP_CH = 8
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Toothed wheel and angle clock
   input wire logic tooth_in,
   input wire logic angle_clk_in,
   // Pulse projector pins
   output logic [PROJ_CH-1:0] proj_pin,
   // Stepper pins
   output logic [STEP_CH-1:0] step_pin,
   // Accumulator
   input wire logic acc_in,
   output logic acc_done,
   output logic [15:0] link_out,
   // Quadrature decoder
   input wire logic quad_a,
   input wire logic quad_b,
   output logic quad_wrap
);
   // Bus slave: every transfer takes one wait state
   logic dphase;
   logic dp_write;
   logic [11:0] wa;
   logic [31:0] rd_mux;
   wire accept = hsel & htrans[1] & hready;
   wire wr = dphase & dp_write;
   wire [6:0] pm_idx = wa[8:2];
   wire pm_hit = (wa < `TWMT_PMEM_TOP) && (pm_idx < `TWMT_PMEM_IMPL);

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         dphase <= 1'b0;
         dp_write <= 1'b0;
         wa <= 12'h000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h0000_0000;
      end else begin
         dphase <= accept;
         hreadyout <= ~accept;
         hresp <= 1'b0;
         if (accept) begin
            wa <= haddr[11:0];
            dp_write <= hwrite;
         end
         if (dphase && !dp_write) begin
            hrdata <= rd_mux;
         end
      end
   end

   // Register decode
   wire wr_tooth = wr & (wa == `TWMT_TOOTH_CTRL);
   wire wr_sctl = wr & (wa == `TWMT_STEP_CTRL);
   wire wr_sk = wr & (wa == `TWMT_STEP_K);
   wire wr_stgt = wr & (wa == `TWMT_STEP_TGT);
   wire wr_slew = wr & (wa == `TWMT_STEP_SLEW);
   wire wr_pat = wr & (wa[11:5] == `TWMT_STEP_PAT_HI);
   wire wr_acc = wr & (wa == `TWMT_ACC_CTRL);
   wire wr_qpos = wr & (wa == `TWMT_QPOS);
   wire wr_stat = wr & (wa == `TWMT_STATUS);
   wire wr_proj = wr & (wa[11:7] == `TWMT_PROJ_HI);

   // Parameter memory, shared by tooth flag and stepper table
   logic [15:0] pmem [0:`TWMT_PMEM_IMPL-1];
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < `TWMT_PMEM_IMPL; i++) begin
            pmem[i] <= 16'h0000;
         end
      end else if (wr && pm_hit) begin
         pmem[pm_idx] <= hwdata[15:0];
      end
   end

   // Internal and angle time bases
   logic [15:0] tbase;
   logic [15:0] angle;
   logic angle_d;
   logic angle_reset;
   wire angle_tick = angle_clk_in & ~angle_d;
   wire [15:0] next_angle = angle_reset ? `TWMT_ANGLE_RESET :
                            angle_tick ? angle + 16'h0001 : angle;
   wire angle_moved = next_angle != angle;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         tbase <= 16'h0000;
         angle <= 16'h0000;
         angle_d <= 1'b0;
      end else begin
         tbase <= tbase + 16'h0001;
         angle_d <= angle_clk_in;
         angle <= next_angle;
      end
   end

   // Tooth reference channel
   logic [31:0] tooth_ctrl;
   logic tooth_d;
   logic [1:0] tooth_hist;
   logic [22:0] tooth_cnt;
   logic [22:0] tooth_period;
   logic [7:0] det_cnt;
   wire tooth_rise = tooth_in & ~tooth_d & tooth_ctrl[`TWMT_TOOTH_EN];
   wire [31:0] new_x = {3'b000, tooth_cnt, 6'b00_0000};
   wire [31:0] prev_x = 32'(tooth_period) * 32'(tooth_ctrl[15:8]);
   // Ratio is in 1/64 steps of the previous period
   wire short_gap = new_x < prev_x;
   wire long_gap = new_x > prev_x;
   wire tooth_gap = tooth_rise & (tooth_hist == 2'h2) &
                    (tooth_ctrl[`TWMT_TOOTH_MISS] ? long_gap : short_gap);
   wire [7:0] faddr = tooth_ctrl[31:24];
   wire [15:0] fword = (faddr[7:1] < `TWMT_PMEM_IMPL) ?
                       pmem[faddr[7:1]] : 16'h0000;
   wire [7:0] fbyte = faddr[0] ? fword[7:0] : fword[15:8];
   wire [7:0] det_next = det_cnt + 8'h01;
   wire gap_hit = tooth_ctrl[`TWMT_TOOTH_FLAG] ? (fbyte != 8'h00)
                  : (det_next >= tooth_ctrl[23:16]);
   assign angle_reset = tooth_gap & gap_hit;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         tooth_ctrl <= `TWMT_CTRL_RST;
         tooth_d <= 1'b0;
         tooth_hist <= 2'h0;
         tooth_cnt <= 23'h00_0000;
         tooth_period <= 23'h00_0000;
         det_cnt <= 8'h00;
      end else begin
         tooth_d <= tooth_in;
         if (wr_tooth) begin
            tooth_ctrl <= hwdata;
         end
         if (tooth_rise) begin
            tooth_cnt <= 23'h00_0001;
            tooth_period <= tooth_cnt;
            if (tooth_hist != 2'h2) begin
               tooth_hist <= tooth_hist + 2'h1;
            end
         end else if (tooth_cnt != 23'h7F_FFFF) begin
            tooth_cnt <= tooth_cnt + 23'h00_0001;
         end
         if (wr_tooth) begin
            det_cnt <= 8'h00;
         end else if (tooth_gap) begin
            det_cnt <= gap_hit ? 8'h00 : det_next;
         end
      end
   end

   // Pulse projectors, all driven by the one reference channel
   logic [31:0] proj_cfg [0:PROJ_CH-1];
   logic [15:0] proj_len [0:PROJ_CH-1];
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         for (int k = 0; k < PROJ_CH; k++) begin
            proj_cfg[k] <= `TWMT_CTRL_RST;
            proj_len[k] <= 16'h0000;
         end
      end else if (wr_proj && (32'(wa[6:3]) < PROJ_CH)) begin
         if (wa[2]) begin
            proj_len[wa[6:3]] <= hwdata[15:0];
         end else begin
            proj_cfg[wa[6:3]] <= hwdata;
         end
      end
   end

   for (genvar k = 0; k < PROJ_CH; k++) begin : g_proj
      twmt_pkg::twmt_proj_e pst;
      logic [22:0] ptmr;
      logic pin_q;
      wire [30:0] prod = 31'(tooth_period) * 31'(proj_cfg[k][23:16]);
      // Fraction of a tooth period, 1/256 steps
      wire [22:0] delay = prod[30:`TWMT_FRAC_SHIFT];
      wire [22:0] len = {7'h00, proj_len[k]};
      wire start_hit = proj_cfg[k][`TWMT_PROJ_EN] & angle_moved &
                       (next_angle == proj_cfg[k][15:0]);
      wire by_time = proj_cfg[k][`TWMT_PROJ_TIME];
      wire end_angle = angle_moved & (next_angle == proj_len[k]);
      assign proj_pin[k] = pin_q;
      always_ff @(posedge sys_clk or posedge rst) begin
         if (rst) begin
            pst <= twmt_pkg::pj_idle;
            ptmr <= 23'h00_0000;
            pin_q <= 1'b0;
         end else begin
            case (pst)
               twmt_pkg::pj_idle: begin
                  if (start_hit) begin
                     pst <= twmt_pkg::pj_delay;
                     ptmr <= delay;
                  end
               end
               twmt_pkg::pj_delay: begin
                  if (ptmr == 23'h00_0000) begin
                     pst <= twmt_pkg::pj_pulse;
                     pin_q <= 1'b1;
                     ptmr <= len;
                  end else begin
                     ptmr <= ptmr - 23'h00_0001;
                  end
               end
               twmt_pkg::pj_pulse: begin
                  // Length by time counts cycles, else by angle
                  if (by_time ? (ptmr <= 23'h00_0001) : end_angle) begin
                     pst <= twmt_pkg::pj_idle;
                     pin_q <= 1'b0;
                  end else if (ptmr != 23'h00_0000) begin
                     ptmr <= ptmr - 23'h00_0001;
                  end
               end
               default: begin
                  pst <= twmt_pkg::pj_idle;
                  pin_q <= 1'b0;
               end
            endcase
         end
      end
   end

   // Stepper, algorithmic or table driven
   logic [6:0] step_ctrl;
   logic [31:0] step_k;
   logic [15:0] step_tgt;
   logic [15:0] step_slew;
   logic [15:0] step_pos;
   logic [15:0] step_tmr;
   logic [5:0] rate;
   logic [5:0] next_rate;
   logic [15:0] pat [0:STEP_CH-1];
   twmt_pkg::twmt_step_e st;
   wire table_mode = step_ctrl[`TWMT_STEP_TABLE];
   wire [5:0] cfg_r = step_ctrl[6:1];
   wire [5:0] lim_r = table_mode ? `TWMT_TSM_MAX_RATE
                                 : `TWMT_SM_MAX_RATE;
   wire [5:0] max_r = (cfg_r == 6'h00) ? 6'h01 :
                      (cfg_r > lim_r) ? lim_r : cfg_r;
   wire step_up = step_tgt > step_pos;
   wire step_fire = (st == twmt_pkg::st_run) && (step_pos != step_tgt) &&
                    (step_tmr == 16'h0000);
   wire [15:0] next_pos = step_up ? step_pos + 16'h0001
                                  : step_pos - 16'h0001;
   wire [15:0] remain = step_up ? step_tgt - next_pos : next_pos - step_tgt;
   wire [15:0] sm_per = step_k[15:0] -
                        16'(step_k[31:16] * {10'h000, next_rate});
   wire [6:0] tab_idx = 7'(`TWMT_TABLE_BASE + {1'b0, next_rate} - 7'h01);
   wire [15:0] tab_per = (next_rate >= max_r) ? step_slew
                                              : pmem[tab_idx];
   wire [15:0] next_per = table_mode ? tab_per : sm_per;
   // Reload one short: the firing cycle is part of the step period
   wire [15:0] next_tmr = (next_per > 16'h0001) ? next_per - 16'h0001
                                                : 16'h0000;
   wire step_req = wr_sctl & hwdata[`TWMT_STEP_REQ];

   always_comb begin
      next_rate = rate;
      // Slow down once the remaining distance fits the ramp
      if ({10'h000, rate} >= remain) begin
         next_rate = (rate > 6'h01) ? rate - 6'h01 : 6'h01;
      end else if (rate < max_r) begin
         next_rate = rate + 6'h01;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         step_ctrl <= 7'h00;
         step_k <= `TWMT_CTRL_RST;
         step_tgt <= 16'h0000;
         step_slew <= 16'h0000;
         step_pos <= 16'h0000;
         step_tmr <= 16'h0000;
         rate <= 6'h00;
         st <= twmt_pkg::st_idle;
      end else begin
         if (wr_sctl) begin
            step_ctrl <= hwdata[6:0];
         end
         if (wr_sk) begin
            step_k <= hwdata;
         end
         if (wr_stgt) begin
            step_tgt <= hwdata[15:0];
         end
         if (wr_slew) begin
            step_slew <= hwdata[15:0];
         end
         case (st)
            twmt_pkg::st_idle: begin
               if (step_req) begin
                  st <= twmt_pkg::st_run;
                  rate <= 6'h00;
                  step_tmr <= 16'h0000;
               end
            end
            twmt_pkg::st_run: begin
               if (step_pos == step_tgt) begin
                  st <= twmt_pkg::st_idle;
               end else if (step_tmr != 16'h0000) begin
                  step_tmr <= step_tmr - 16'h0001;
               end else begin
                  step_pos <= next_pos;
                  rate <= next_rate;
                  step_tmr <= next_tmr;
               end
            end
            default: st <= twmt_pkg::st_idle;
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         for (int k = 0; k < STEP_CH; k++) begin
            pat[k] <= 16'h0000;
         end
      end else begin
         for (int k = 0; k < STEP_CH; k++) begin
            if (wr_pat && (32'(wa[4:2]) == k)) begin
               pat[k] <= hwdata[15:0];
            end else if (step_fire) begin
               pat[k] <= step_up ? {pat[k][14:0], pat[k][15]}
                                 : {pat[k][0], pat[k][15:1]};
            end
         end
      end
   end

   for (genvar k = 0; k < STEP_CH; k++) begin : g_step
      assign step_pin[k] = pat[k][0];
   end

   // Period and high-time accumulator
   logic [31:0] acc_ctrl;
   logic acc_d;
   logic acc_run;
   logic [23:0] meas;
   logic [23:0] acc_sum;
   logic [23:0] acc_res;
   logic [7:0] acc_n;
   wire acc_en = acc_ctrl[`TWMT_ACC_EN];
   wire acc_high = acc_ctrl[`TWMT_ACC_HIGH];
   wire acc_rise = acc_en & acc_in & ~acc_d;
   wire acc_fall = acc_en & ~acc_in & acc_d;
   wire meas_done = acc_run & (acc_high ? acc_fall : acc_rise);
   wire [23:0] sum_next = acc_sum + meas;
   wire [7:0] n_next = acc_n + 8'h01;
   wire [7:0] n_goal = (acc_ctrl[15:8] == 8'h00) ? 8'h01 : acc_ctrl[15:8];
   wire acc_last = meas_done & (n_next >= n_goal);
   wire [3:0] lk_cnt = (acc_ctrl[23:20] > `TWMT_LINK_MAX) ? `TWMT_LINK_MAX
                                                          : acc_ctrl[23:20];
   wire [15:0] lk_ones = 16'((17'h0_0001 << lk_cnt) - 17'h0_0001);
   wire [31:0] lk_dbl = {16'h0000, lk_ones} << acc_ctrl[19:16];
   wire [15:0] lk_mask = lk_dbl[15:0] | lk_dbl[31:16];

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         acc_ctrl <= `TWMT_CTRL_RST;
         acc_d <= 1'b0;
         acc_run <= 1'b0;
         meas <= 24'h00_0000;
         acc_sum <= 24'h00_0000;
         acc_res <= 24'h00_0000;
         acc_n <= 8'h00;
         acc_done <= 1'b0;
         link_out <= 16'h0000;
      end else begin
         acc_d <= acc_in;
         acc_done <= acc_last;
         link_out <= (acc_last && acc_ctrl[`TWMT_ACC_LINK]) ? lk_mask
                                                           : 16'h0000;
         if (wr_acc) begin
            acc_ctrl <= hwdata;
            acc_run <= 1'b0;
            acc_sum <= 24'h00_0000;
            acc_n <= 8'h00;
         end else begin
            if (acc_rise) begin
               acc_run <= 1'b1;
               meas <= 24'h00_0001;
            end else if (meas != 24'hFF_FFFF) begin
               meas <= meas + 24'h00_0001;
            end
            if (acc_last) begin
               acc_res <= acc_ctrl[`TWMT_ACC_WIDE] ? sum_next
                          : {8'h00, sum_next[15:0]};
               acc_sum <= 24'h00_0000;
               acc_n <= 8'h00;
            end else if (meas_done) begin
               acc_sum <= sum_next;
               acc_n <= n_next;
            end
         end
      end
   end

   // Quadrature decoder
   logic qa_d;
   logic qb_d;
   logic [15:0] qpos;
   logic [15:0] qstamp;
   wire qa_edge = quad_a ^ qa_d;
   wire qb_edge = quad_b ^ qb_d;
   wire q_valid = qa_edge ^ qb_edge;
   wire q_up = qa_edge ? (quad_a != quad_b) : (quad_a == quad_b);
   wire q_wrap = q_valid & (q_up ? (qpos == 16'hFFFF) : (qpos == 16'h0000));

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         qa_d <= 1'b0;
         qb_d <= 1'b0;
         qpos <= 16'h0000;
         qstamp <= 16'h0000;
         quad_wrap <= 1'b0;
      end else begin
         qa_d <= quad_a;
         qb_d <= quad_b;
         quad_wrap <= q_wrap & ~wr_qpos;
         // Host write wins over a same-cycle count
         if (wr_qpos) begin
            qpos <= hwdata[15:0];
         end else if (q_valid) begin
            qpos <= q_up ? qpos + 16'h0001 : qpos - 16'h0001;
         end
         if (q_valid) begin
            qstamp <= tbase;
         end
      end
   end

   // Sticky status, a new event beats a same-cycle clear
   logic [3:0] status;
   wire [3:0] st_set = {angle_reset, tooth_gap, q_wrap & ~wr_qpos, acc_last};
   wire [3:0] st_clr = wr_stat ? hwdata[3:0] : 4'h0;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         status <= 4'h0;
      end else begin
         status <= (status & ~st_clr) | st_set;
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (pm_hit) begin
         rd_mux = {16'h0000, pmem[pm_idx]};
      end else if (wa == `TWMT_TOOTH_CTRL) begin
         rd_mux = tooth_ctrl;
      end else if (wa == `TWMT_TOOTH_STAT) begin
         rd_mux = {det_cnt, 1'b0, tooth_period};
      end else if (wa == `TWMT_ANGLE) begin
         rd_mux = {16'h0000, angle};
      end else if (wa == `TWMT_TBASE) begin
         rd_mux = {16'h0000, tbase};
      end else if (wa == `TWMT_STEP_CTRL) begin
         rd_mux = {24'h00_0000, st == twmt_pkg::st_run, step_ctrl};
      end else if (wa == `TWMT_STEP_K) begin
         rd_mux = step_k;
      end else if (wa == `TWMT_STEP_TGT) begin
         rd_mux = {step_pos, step_tgt};
      end else if (wa == `TWMT_STEP_SLEW) begin
         rd_mux = {16'h0000, step_slew};
      end else if ((wa[11:5] == `TWMT_STEP_PAT_HI) &&
                   (32'(wa[4:2]) < STEP_CH)) begin
         rd_mux = {16'h0000, pat[wa[4:2]]};
      end else if (wa == `TWMT_ACC_CTRL) begin
         rd_mux = acc_ctrl;
      end else if (wa == `TWMT_ACC_RES) begin
         rd_mux = {8'h00, acc_res};
      end else if (wa == `TWMT_QPOS) begin
         rd_mux = {16'h0000, qpos};
      end else if (wa == `TWMT_QSTAMP) begin
         rd_mux = {16'h0000, qstamp};
      end else if (wa == `TWMT_STATUS) begin
         rd_mux = {28'h000_0000, status};
      end else if ((wa[11:7] == `TWMT_PROJ_HI) &&
                   (32'(wa[6:3]) < PROJ_CH)) begin
         rd_mux = wa[2] ? {16'h0000, proj_len[wa[6:3]]}
                        : proj_cfg[wa[6:3]];
      end
   end
endmodule : twmt_top

// [tb/twmt_monitor.sv]
`timescale 1ns/10ps
module twmt_monitor (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Bus
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   // Events
   input wire logic acc_done,
   input wire logic [15:0] link_out,
   input wire logic quad_a,
   input wire logic quad_b,
   input wire logic quad_wrap
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   sequence s_take;
      hsel && htrans[1] && hready;
   endsequence
   sequence s_wait;
      !hreadyout ##1 hreadyout;
   endsequence
   property p_wait;
      s_take |=> s_wait;
   endproperty
   a_wait: assert property (p_wait)
      else $error("bus wait state not exactly one cycle");
   property p_okay;
      hresp == 1'b0;
   endproperty
   a_okay: assert property (p_okay)
      else $error("bus response not okay");
   property p_short;
      !hreadyout |=> hreadyout;
   endproperty
   a_short: assert property (p_short)
      else $error("bus stalled more than one cycle");
   property p_hold;
      !hreadyout |-> $stable(hrdata);
   endproperty
   a_hold: assert property (p_hold)
      else $error("read data moved during wait state");
   // Back-to-back wraps are legal, so tie each one to an input edge
   property p_wrap_pulse;
      quad_wrap |-> ($past(quad_a) != $past(quad_a, 2)) ||
         ($past(quad_b) != $past(quad_b, 2));
   endproperty
   a_wrap_pulse: assert property (p_wrap_pulse)
      else $error("wrap event without a quadrature edge");
   property p_done_pulse;
      acc_done |=> !acc_done;
   endproperty
   a_done_pulse: assert property (p_done_pulse)
      else $error("accumulation done longer than one cycle");
   property p_link_done;
      |link_out |-> acc_done;
   endproperty
   a_link_done: assert property (p_link_done)
      else $error("link mask without accumulation done");
   property p_link_max;
      $countones(link_out) <= 8;
   endproperty
   a_link_max: assert property (p_link_max)
      else $error("link block wider than eight channels");
endmodule : twmt_monitor

bind twmt_top twmt_monitor u_twmt_monitor (.sys_clk(sys_clk), .rst(rst),
   .hsel(hsel), .htrans(htrans), .hready(hready), .hreadyout(hreadyout),
   .hresp(hresp), .hrdata(hrdata), .acc_done(acc_done),
   .link_out(link_out), .quad_a(quad_a), .quad_b(quad_b),
   .quad_wrap(quad_wrap));

// [tb/twmt_field_model.sv]
`timescale 1ns/10ps
module twmt_field_model (
   // Clock
   input wire logic sys_clk,
   // Sensor pins
   output logic tooth_in,
   output logic angle_clk_in,
   output logic acc_in,
   output logic quad_a,
   output logic quad_b
);
   initial begin
      {tooth_in, angle_clk_in, acc_in, quad_a, quad_b} = 5'h00;
   end
   // Gap after the last edge equals per, so calls chain seamlessly
   task edges(input int sel, input int per, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge sys_clk);
         if (sel == 0) tooth_in <= 1'b1; else acc_in <= 1'b1;
         repeat (per / 2) @(posedge sys_clk);
         if (sel == 0) tooth_in <= 1'b0; else acc_in <= 1'b0;
         repeat (per - per / 2 - 1) @(posedge sys_clk);
      end
   endtask : edges
   // Indicator rests low between ticks
   task angle_tick;
      @(posedge sys_clk);
      angle_clk_in <= 1'b1;
      repeat (2) @(posedge sys_clk);
      angle_clk_in <= 1'b0;
      repeat (2) @(posedge sys_clk);
   endtask : angle_tick
   // One edge per call, never both inputs at once
   task quad_step(input logic up);
      @(posedge sys_clk);
      quad_a <= up ? ~quad_b : quad_b;
      quad_b <= up ? quad_a : ~quad_a;
      repeat (4) @(posedge sys_clk);
   endtask : quad_step
endmodule : twmt_field_model

// [tb/tb.sv]
`timescale 1ns/10ps
`include "twmt_defs.svh"
module tb;
   logic sys_clk, rst, hsel, hwrite, hreadyout, hresp, acc_done, quad_wrap;
   logic tooth_in, angle_clk_in, acc_in, quad_a, quad_b;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, rdata;
   logic [14:0] proj_pin;
   logic [7:0] step_pin;
   logic [15:0] link_out, lnk;
   logic [31:0] wraps = 32'h0000_0000;
   int checks = 0;
   int mismatches = 0;
   twmt_top u_twmt_top (.sys_clk(sys_clk), .rst(rst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .tooth_in(tooth_in),
      .angle_clk_in(angle_clk_in), .proj_pin(proj_pin),
      .step_pin(step_pin), .acc_in(acc_in), .acc_done(acc_done),
      .link_out(link_out), .quad_a(quad_a), .quad_b(quad_b),
      .quad_wrap(quad_wrap));
   twmt_field_model u_twmt_field_model (.sys_clk(sys_clk),
      .tooth_in(tooth_in), .angle_clk_in(angle_clk_in), .acc_in(acc_in),
      .quad_a(quad_a), .quad_b(quad_b));
   always @(posedge sys_clk) if (quad_wrap === 1'b1) wraps <= wraps + 1;
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task complete_run;
      $display("checks=%0d mismatches=%0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : complete_run
   task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {20'h0_0000, a};
      hwrite <= w;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      rdata = hrdata;
   endtask : bus
   task test_regs;
      bus(1'b0, `TWMT_TOOTH_CTRL, 32'h0);
      check(rdata, `TWMT_CTRL_RST);
      bus(1'b1, 12'h18C, 32'h0000_A5C3);
      bus(1'b0, 12'h18C, 32'h0);
      check(rdata, 32'h0000_A5C3);
      bus(1'b1, 12'h190, 32'h0000_A5C3);
      bus(1'b0, 12'h190, 32'h0);
      check(rdata, 32'h0000_0000);
      bus(1'b0, 12'h3F0, 32'h0);
      check(rdata, 32'h0000_0000);
   endtask : test_regs
   // Missing-tooth mode, ratio 1.5, angle reset on first detection
   task test_tooth;
      bus(1'b1, `TWMT_TOOTH_CTRL, 32'h0001_6003);
      u_twmt_field_model.edges(0, 10, 3);
      u_twmt_field_model.edges(0, 30, 1);
      u_twmt_field_model.edges(0, 10, 1);
      bus(1'b0, `TWMT_TOOTH_STAT, 32'h0);
      check(rdata & 32'h007F_FFFF, 32'h0000_001E);
      bus(1'b0, `TWMT_STATUS, 32'h0);
      check(rdata & 32'h0000_000C, 32'h0000_000C);
      bus(1'b0, `TWMT_ANGLE, 32'h0);
      check(rdata & 32'h0000_FFFF, 32'h0000_FFFF);
      u_twmt_field_model.angle_tick;
      bus(1'b0, `TWMT_ANGLE, 32'h0);
      check(rdata & 32'h0000_FFFF, 32'h0000_0000);
   endtask : test_tooth
   // Two periods of 10 summed, links to channels 3 and 4
   task test_acc;
      int n;
      bus(1'b1, `TWMT_ACC_CTRL, 32'h0123_0201);
      fork
         u_twmt_field_model.edges(1, 10, 4);
         begin
            n = 0;
            while (acc_done !== 1'b1 && n < 100) begin
               @(posedge sys_clk);
               n++;
            end
            lnk = link_out;
         end
      join
      check({16'h0000, lnk}, 32'h0000_0018);
      bus(1'b0, `TWMT_ACC_RES, 32'h0);
      check(rdata, 32'h0000_0014);
      bus(1'b0, `TWMT_STATUS, 32'h0);
      check(rdata & 32'h0000_0001, 32'h0000_0001);
   endtask : test_acc
   task test_step;
      int n;
      bus(1'b1, 12'h220, 32'h0000_0001);
      bus(1'b1, 12'h224, 32'h0000_5555);
      bus(1'b1, `TWMT_STEP_K, 32'h0002_0014);
      bus(1'b1, `TWMT_STEP_TGT, 32'h0000_0003);
      bus(1'b1, `TWMT_STEP_CTRL, 32'h0000_0082);
      // Pin 1 toggles on every step; rate 1 gives 20 - 2 = 18 cycles
      n = 0;
      while (step_pin[1] !== 1'b0) @(posedge sys_clk);
      while (step_pin[1] !== 1'b1 && n < 100) begin
         @(posedge sys_clk);
         n++;
      end
      check(n, 32'h0000_0012);
      n = 0;
      do begin
         bus(1'b0, `TWMT_STEP_CTRL, 32'h0);
         n++;
      end while (rdata[7] === 1'b1 && n < 200);
      bus(1'b0, `TWMT_STEP_TGT, 32'h0);
      check(rdata >> 16, 32'h0000_0003);
      bus(1'b0, 12'h220, 32'h0);
      check(rdata & 32'h0000_FFFF, 32'h0000_0008);
      check({31'h0, step_pin[0]}, 32'h0000_0000);
   endtask : test_step
   task test_quad;
      bus(1'b1, `TWMT_QPOS, 32'h0000_FFFF);
      u_twmt_field_model.quad_step(1'b1);
      bus(1'b0, `TWMT_QPOS, 32'h0);
      check(rdata & 32'h0000_FFFF, 32'h0000_0000);
      check(wraps, 32'h0000_0001);
      u_twmt_field_model.quad_step(1'b0);
      u_twmt_field_model.quad_step(1'b0);
      bus(1'b0, `TWMT_QPOS, 32'h0);
      check(rdata & 32'h0000_FFFF, 32'h0000_FFFE);
      check(wraps, 32'h0000_0002);
   endtask : test_quad
   // Projector 0 off a 30-cycle tooth: half-period delay, 4-cycle pulse
   task test_proj;
      int n;
      int f;
      bus(1'b1, 12'h284, 32'h0000_0004);
      bus(1'b1, 12'h280, 32'hC080_0001);
      n = 0;
      f = 0;
      fork
         u_twmt_field_model.angle_tick;
         for (int i = 1; i <= 40; i++) begin
            @(posedge sys_clk);
            if (proj_pin[0] === 1'b1) begin
               n++;
               if (f == 0) f = i;
            end
         end
      join
      check(f, 32'h0000_0013);
      check(n, 32'h0000_0004);
   endtask : test_proj
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   initial begin
      {rst, hsel, hwrite, htrans, hsize} = 8'h82;
      {haddr, hwdata} = 64'h0;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      test_regs;
      test_tooth;
      test_acc;
      test_step;
      test_quad;
      test_proj;
      complete_run;
   end
   // Whole sequence needs well under 2000 cycles
   initial begin
      repeat (20000) @(posedge sys_clk);
      mismatches++;
      complete_run;
   end
endmodule : tb
